/* flash_power_up_write_inhibit_bench.sv */
/*
  Self-checking bench for fpwi_seq: AXI4-Lite tasks and power tests.
  Assumes fpwi_host_model drives the supply flag of the design.
*/
`timescale 1ns/100ps
module flash_power_up_write_inhibit_bench;
  import fpwi_pkg::*;
  localparam int INHIB = 4000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic powerReq = 1'b0;
  logic supplyOk, selectOk, awReady, wReady, bValid, arReady, rValid;
  logic writeAllowed, readAllowed;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'h0;
  logic [1:0] bResp, rResp, rs;
  logic [31:0] rData, rd;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int tRise = 0;
  fpwi_cmd_t wcls[9] = '{write_enable_cmd, page_program_cmd, dual_in_program_cmd, otp_program_cmd,
    small_erase_cmd, block_erase_cmd, chip_erase_cmd, status_write_cmd, lock_write_cmd};

  fpwi_host_model #(.SEL_CYCLES(SELECT_DELAY_CYCLES)) host (.mclk(mclk), .rst_n(rst_n),
    .powerReq(powerReq), .supplyOk(supplyOk), .selectOk(selectOk));

  fpwi_seq #(.INHIBIT_CYCLES(INHIB)) DUT (.mclk(mclk), .rst_n(rst_n), .supplyOk(supplyOk),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .writeAllowed(writeAllowed), .readAllowed(readAllowed));

  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // Watchdog: whole run needs about 10500 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task conclude;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write: both channels offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awAddr <= a;
    wData <= d;
    wStrb <= 4'hf;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge mclk);
      if (!awDone && awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bValid !== 1'b1);
    rs = bResp;
    bReady <= 1'b0;
    // Extra edge so the next call never re-drives in this step
    @(posedge mclk);
  endtask : wr

  task rdr(input logic [7:0] a);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge mclk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge mclk); while (rValid !== 1'b1);
    rd = rData;
    rs = rResp;
    rReady <= 1'b0;
    @(posedge mclk);
  endtask : rdr

  task cmd(input fpwi_cmd_t c);
    wr(CMD_OFS, {24'h0, c});
  endtask : cmd

  task sts(input logic [31:0] m, input logic [31:0] e);
    rdr(STATUS_OFS);
    chk(rd & m, e);
  endtask : sts

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    sts(32'h0fff, 32'h0800);
    cmd(write_enable_cmd);
    sts(32'h0fff, 32'h0800);
    chk({30'h0, writeAllowed, readAllowed}, 32'h0);
    $display("test supply_low done");

    wr(CTRL_OFS, 32'h1);
    powerReq <= 1'b1;
    tRise = cyc;
    while (readAllowed !== 1'b1) @(posedge mclk);
    chk(32'((cyc - tRise) inside {[SELECT_DELAY_CYCLES:SELECT_DELAY_CYCLES + 6]}), 32'h1);
    chk({31'h0, writeAllowed}, 32'h0);
    sts(32'h1fff, 32'h0100);
    rdr(ARRAY_OFS);
    chk(rd, {24'h0, ARRAY_ERASED});
    rdr(LOCK_OFS);
    chk(rd, 32'h0);
    foreach (wcls[i]) begin
      wr(CTRL_OFS, 32'h1);
      cmd(wcls[i]);
      sts(32'h1fff, 32'h1100);
    end
    wr(CTRL_OFS, 32'h1);
    cmd(read_cmd);
    sts(32'h1fff, 32'h0100);
    chk({31'h0, writeAllowed}, 32'h0);
    // Host holds off writes until both delays have run out
    while (!(writeAllowed === 1'b1 && selectOk === 1'b1)) @(posedge mclk);
    chk(32'((cyc - tRise) inside {[INHIB:INHIB + 6]}), 32'h1);
    sts(32'h1fff, 32'h0300);
    $display("test power_up done");

    cmd(page_program_cmd);
    sts(32'h1fff, 32'h1300);
    wr(CTRL_OFS, 32'h1);
    for (int i = 1; i < 7; i++) begin
      cmd(write_enable_cmd);
      sts(32'h1fff, 32'h0302);
      cmd(wcls[i]);
      sts(32'h0001, 32'h0001);
      repeat (20) @(posedge mclk);
      sts(32'h1fff, 32'h0300);
    end
    cmd(write_enable_cmd);
    wr(CMD_OFS, {16'h0, 8'hb4, status_write_cmd});
    repeat (20) @(posedge mclk);
    sts(32'h00fc, 32'h00b4);
    cmd(write_enable_cmd);
    wr(CMD_OFS, {8'h0, 8'h3c, 8'ha5, lock_write_cmd});
    repeat (20) @(posedge mclk);
    rdr(LOCK_OFS);
    chk(rd, 32'h003c00a5);
    $display("test writes done");

    cmd(deep_cmd);
    sts(32'h1402, 32'h0400);
    cmd(write_enable_cmd);
    sts(32'h1402, 32'h1400);
    wr(CTRL_OFS, 32'h1);
    cmd(wake_cmd);
    sts(32'h1402, 32'h0000);
    cmd(deep_cmd);
    $display("test deep done");

    powerReq <= 1'b0;
    repeat (4) @(posedge mclk);
    sts(32'h0fff, 32'h0800);
    chk({30'h0, writeAllowed, readAllowed}, 32'h0);
    cmd(read_cmd);
    sts(32'h0fff, 32'h0800);
    powerReq <= 1'b1;
    repeat (2000) @(posedge mclk);
    powerReq <= 1'b0;
    repeat (5) @(posedge mclk);
    powerReq <= 1'b1;
    tRise = cyc;
    while (writeAllowed !== 1'b1) @(posedge mclk);
    chk(32'((cyc - tRise) inside {[INHIB:INHIB + 6]}), 32'h1);
    wr(CTRL_OFS, 32'h1);
    sts(32'h1fff, 32'h0300);
    rdr(LOCK_OFS);
    chk(rd, 32'h0);
    $display("test power_cycle done");

    rdr(ID_OFS);
    chk(rd, {16'h0, ID_VALUE});
    rdr(8'h18);
    chk({rd[29:0], rs}, {30'h0, AXI_SLVERR});
    wr(8'h18, 32'h0);
    chk({30'h0, rs}, {30'h0, AXI_SLVERR});
    $display("test map done");
    conclude();
  end
endmodule : flash_power_up_write_inhibit_bench

/* fpwi_host_model.sv */
/*
  Behavioural model of the host side: raises and drops the supply flag
  on request and tracks when chip selection becomes legal.
  Assumes one mclk domain and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module fpwi_host_model #(
  parameter int SEL_CYCLES = 3000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic powerReq,
  output logic supplyOk,
  output logic selectOk
);
  logic [15:0] selCnt;
  logic [15:0] next_selCnt;

  // Select delay restarts on every supply loss
  always_comb begin
    next_selCnt = selCnt;
    if (!supplyOk) begin
      next_selCnt = 16'h0000;
    end else if (selCnt != 16'(SEL_CYCLES)) begin
      next_selCnt = selCnt + 16'h0001;
    end
  end

  // Supply follows the request one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supplyOk <= 1'b0;
      selCnt <= 16'h0000;
    end else begin
      supplyOk <= powerReq;
      selCnt <= next_selCnt;
    end
  end

  // Host may select only after the delay, never while supply is low
  assign selectOk = supplyOk && (selCnt == 16'(SEL_CYCLES));
endmodule : fpwi_host_model

/* fpwi_pkg.sv */
/*
  Constants, register map and enumerations for the flash power-up
  write-inhibit sequencer.
  Assumes a 100 MHz mclk and a 32-bit AXI4-Lite register bus.
*/
package fpwi_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int WRITE_INHIBIT_DELAY_MS = 1;
  localparam int WRITE_INHIBIT_DELAY_MAX_MS = 10;
  localparam int WRITE_INHIBIT_CYCLES = WRITE_INHIBIT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int SELECT_DELAY_US = 30;
  localparam int SELECT_DELAY_CYCLES = SELECT_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int SEL_W = 13;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] LOCK_OFS = 8'h0c;
  localparam logic [7:0] ARRAY_OFS = 8'h10;
  localparam logic [7:0] ID_OFS = 8'h14;

  // Field positions
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int CTRL_DONE_BIT = 0;
  localparam int STS_READY_BIT = 8;
  localparam int STS_WRITE_OK_BIT = 9;
  localparam int STS_DEEP_BIT = 10;
  localparam int STS_POR_BIT = 11;
  localparam int STS_REJECT_BIT = 12;
  localparam int NUM_SECTORS = 8;

  // Reset and delivery values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ARRAY_ERASED = 8'hff;
  localparam logic [15:0] ID_VALUE = 16'h5a5a;  // Arbitrary identity value
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Instruction opcodes as written into the command register
  typedef enum logic [7:0] {
    write_enable_cmd = 8'h06,
    page_program_cmd = 8'h02,
    dual_in_program_cmd = 8'ha2,
    otp_program_cmd = 8'h42,
    small_erase_cmd = 8'h20,
    block_erase_cmd = 8'hd8,
    chip_erase_cmd = 8'hc7,
    status_write_cmd = 8'h01,
    lock_write_cmd = 8'he5,
    read_cmd = 8'h03,
    deep_cmd = 8'hb9,
    wake_cmd = 8'hab
  } fpwi_cmd_t;

  typedef enum logic [1:0] {PWR_OFF, PWR_WAIT, PWR_READ, PWR_FULL} fpwi_pwr_t;
endpackage : fpwi_pkg

/* fpwi_seq.sv */
/*
  Power-up write-inhibit sequencer of a serial flash instruction unit.
  Instructions arrive through an AXI4-Lite command register; the block
  gates them by supply state and holds the power-up state of the flags.
  Assumes supplyOk comes from an external threshold detector, synchronous
  to mclk, and that the host keeps chip select high during power changes.
*/
`timescale 1ns/100ps
module fpwi_seq #(
  parameter int INHIBIT_CYCLES = fpwi_pkg::WRITE_INHIBIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supplyOk,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic writeAllowed,
  output logic readAllowed
);
  import fpwi_pkg::*;

  fpwi_timer_if tif ();
  assign tif.supplyOk = supplyOk;

  fpwi_timer #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // Write-class decode, shared by gating and latch logic
  function automatic logic isWriteClass(input logic [7:0] op);
    case (op)
      write_enable_cmd, page_program_cmd, dual_in_program_cmd, otp_program_cmd,
      small_erase_cmd, block_erase_cmd, chip_erase_cmd, status_write_cmd,
      lock_write_cmd: isWriteClass = 1'b1;
      default: isWriteClass = 1'b0;
    endcase
  endfunction : isWriteClass

  // Program, erase, status write and lock write need the enable latch
  function automatic logic needsLatch(input logic [7:0] op);
    needsLatch = isWriteClass(op) && op != write_enable_cmd;
  endfunction : needsLatch

  fpwi_pwr_t pwr;
  fpwi_pwr_t next_pwr;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [NUM_SECTORS-1:0] writeLock;
  logic [NUM_SECTORS-1:0] next_writeLock;
  logic [NUM_SECTORS-1:0] lockDown;
  logic [NUM_SECTORS-1:0] next_lockDown;
  logic deepMode;
  logic next_deepMode;
  logic rejected;
  logic next_rejected;
  logic [3:0] busyCnt;
  logic [3:0] next_busyCnt;

  // AXI state
  logic awHeld;
  logic next_awHeld;
  logic wHeld;
  logic next_wHeld;
  logic [7:0] awAddr;
  logic [7:0] next_awAddr;
  logic [31:0] wData;
  logic [31:0] next_wData;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic wrAllow;
  logic next_wrAllow;
  logic rdAllow;
  logic next_rdAllow;

  logic doWrite;
  logic [7:0] op;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign op = wData[7:0];

  // Power state follows supply and the two delays
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_OFF: if (supplyOk) next_pwr = PWR_WAIT;
      PWR_WAIT: if (tif.selectDone) next_pwr = tif.inhibitDone ? PWR_FULL : PWR_READ;
      PWR_READ: if (tif.inhibitDone) next_pwr = PWR_FULL;
      PWR_FULL: next_pwr = PWR_FULL;
      default: next_pwr = PWR_OFF;
    endcase
    if (!supplyOk) next_pwr = PWR_OFF;
    next_wrAllow = (next_pwr == PWR_FULL);
    next_rdAllow = (next_pwr == PWR_READ) || (next_pwr == PWR_FULL);
  end

  // Instruction execution and power-up state
  always_comb begin
    next_status = status;
    next_writeLock = writeLock;
    next_lockDown = lockDown;
    next_deepMode = deepMode;
    next_rejected = rejected;
    next_busyCnt = busyCnt;
    if (busyCnt != 4'h0) begin
      next_busyCnt = busyCnt - 4'h1;
      if (busyCnt == 4'h1) begin
        next_status[BUSY_BIT] = 1'b0;
        next_status[LATCH_BIT] = 1'b0;
      end
    end
    if (doWrite && awAddr == CMD_OFS && s_axi_wstrb[0]) begin
      if (pwr == PWR_OFF || pwr == PWR_WAIT) begin
        next_rejected = 1'b1;
      end else if (deepMode) begin
        if (op == wake_cmd) next_deepMode = 1'b0;
        else next_rejected = 1'b1;
      end else if (isWriteClass(op) && !tif.inhibitDone) begin
        next_rejected = 1'b1;
      end else if (status[BUSY_BIT]) begin
        next_rejected = 1'b1;
      end else if (op == write_enable_cmd) begin
        next_status[LATCH_BIT] = 1'b1;
      end else if (needsLatch(op)) begin
        if (!status[LATCH_BIT]) begin
          next_rejected = 1'b1;
        end else begin
          next_status[BUSY_BIT] = 1'b1;
          next_busyCnt = 4'hf;
          if (op == lock_write_cmd) begin
            next_writeLock = writeLock | wData[8 +: NUM_SECTORS];
            next_lockDown = lockDown | wData[16 +: NUM_SECTORS];
          end
          if (op == status_write_cmd) next_status[7:2] = wData[15:10];
        end
      end else if (op == deep_cmd) begin
        next_deepMode = 1'b1;
      end
    end else if (doWrite && awAddr == CTRL_OFS && s_axi_wstrb[0] && wData[CTRL_DONE_BIT]) begin
      next_rejected = 1'b0;
    end
    // Hold everything at power-up values while supply is low
    if (!supplyOk) begin
      next_status = STATUS_RESET;
      next_writeLock = '0;
      next_lockDown = '0;
      next_deepMode = 1'b0;
      next_rejected = 1'b0;
      next_busyCnt = 4'h0;
    end
  end

  // AXI4-Lite slave; address and data may come in either order
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (awAddr == CTRL_OFS || awAddr == CMD_OFS) ? AXI_OKAY : AXI_SLVERR;
    end
    if (bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      case (s_axi_araddr)
        CTRL_OFS: next_rdata = 32'h0;
        CMD_OFS: next_rdata = 32'h0;
        STATUS_OFS: next_rdata = {19'h0, rejected, ~supplyOk, deepMode, wrAllow, rdAllow, status};
        LOCK_OFS: next_rdata = {8'h0, lockDown, 8'h0, writeLock};
        ARRAY_OFS: next_rdata = {24'h0, ARRAY_ERASED};
        ID_OFS: next_rdata = {16'h0, ID_VALUE};
        default: begin
          next_rdata = 32'h0;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
    if (rvalid && s_axi_rready) next_rvalid = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= PWR_OFF;
      status <= STATUS_RESET;
      writeLock <= '0;
      lockDown <= '0;
      deepMode <= 1'b0;
      rejected <= 1'b0;
      busyCnt <= 4'h0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h0;
      wData <= 32'h0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= AXI_OKAY;
      wrAllow <= 1'b0;
      rdAllow <= 1'b0;
    end else begin
      pwr <= next_pwr;
      status <= next_status;
      writeLock <= next_writeLock;
      lockDown <= next_lockDown;
      deepMode <= next_deepMode;
      rejected <= next_rejected;
      busyCnt <= next_busyCnt;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      wrAllow <= next_wrAllow;
      rdAllow <= next_rdAllow;
    end
  end

  // Ready held low while an item waits; outputs are flop based
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !next_awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_wHeld && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign writeAllowed = wrAllow;
  assign readAllowed = rdAllow;

  sequence supplyLost_s;
    !supplyOk;
  endsequence
  sequence cleared_s;
    status == STATUS_RESET && writeLock == '0 && lockDown == '0 && !deepMode;
  endsequence

  supply_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
    supplyLost_s |=> cleared_s)
    else $error("state not reset on low supply");
  drop_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !supplyOk |=> !wrAllow && !rdAllow)
    else $error("access allowed without supply");
  write_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wrAllow |-> tif.inhibitDone)
    else $error("writes allowed before inhibit delay");
  read_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    supplyOk && tif.selectDone && $past(supplyOk) |=> rdAllow)
    else $error("reads not allowed after select delay");
  standby_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(supplyOk) |=> !deepMode)
    else $error("powered up in deep mode");
  flags_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(supplyOk) |=> !status[LATCH_BIT] && !status[BUSY_BIT])
    else $error("flags not clear at power-up");
  locks_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(supplyOk) |=> writeLock == '0 && lockDown == '0)
    else $error("lock bits not clear at power-up");
  deep_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
    deepMode && supplyOk && !(doWrite && awAddr == CMD_OFS && op == wake_cmd) |=> $stable(status))
    else $error("instruction acted in deep mode");
  latch_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    doWrite && awAddr == CMD_OFS && s_axi_wstrb[0] && op == write_enable_cmd && supplyOk && !deepMode
    && tif.inhibitDone && !status[BUSY_BIT] && pwr != PWR_OFF && pwr != PWR_WAIT |=> status[LATCH_BIT])
    else $error("enable latch not set");
  array_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_arvalid && !rvalid && s_axi_araddr == ARRAY_OFS |=> rdata[7:0] == ARRAY_ERASED)
    else $error("array not erased");
endmodule : fpwi_seq

/* fpwi_timer.sv */
/*
  Power-up delay timer: counts the select and write-inhibit delays.
  Assumes supplyOk is synchronous to mclk.
*/
`timescale 1ns/100ps
module fpwi_timer #(
  parameter int INHIBIT_CYCLES = fpwi_pkg::WRITE_INHIBIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  fpwi_timer_if.timer tif
);
  import fpwi_pkg::*;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [SEL_W-1:0] selCnt;
  logic [SEL_W-1:0] next_selCnt;
  logic selectDone;
  logic next_selectDone;
  logic inhibitDone;
  logic next_inhibitDone;

  // Counters restart whenever the supply drops
  always_comb begin
    next_cnt = cnt;
    next_selCnt = selCnt;
    next_selectDone = selectDone;
    next_inhibitDone = inhibitDone;
    if (!tif.supplyOk) begin
      next_cnt = '0;
      next_selCnt = '0;
      next_selectDone = 1'b0;
      next_inhibitDone = 1'b0;
    end else begin
      if (!inhibitDone) begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(INHIBIT_CYCLES - 1)) next_inhibitDone = 1'b1;
      end
      if (!selectDone) begin
        next_selCnt = selCnt + 1'b1;
        if (selCnt == SEL_W'(SELECT_DELAY_CYCLES - 1)) next_selectDone = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      selCnt <= '0;
      selectDone <= 1'b0;
      inhibitDone <= 1'b0;
    end else begin
      cnt <= next_cnt;
      selCnt <= next_selCnt;
      selectDone <= next_selectDone;
      inhibitDone <= next_inhibitDone;
    end
  end

  assign tif.selectDone = selectDone;
  assign tif.inhibitDone = inhibitDone;

  // Terminal flag needs the full count with the supply held
  inhibit_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(inhibitDone) |-> $past(tif.supplyOk) && cnt == CNT_W'(INHIBIT_CYCLES))
    else $error("inhibit flag set early");
endmodule : fpwi_timer

/* fpwi_timer_if.sv */
/*
  Interface carrying the write-inhibit timer handshake.
  Assumes one clock domain shared by timer and sequencer.
*/
`timescale 1ns/100ps
interface fpwi_timer_if;
  logic supplyOk;
  logic selectDone;
  logic inhibitDone;
  modport timer (input supplyOk, output selectDone, output inhibitDone);
  modport seq (output supplyOk, input selectDone, input inhibitDone);
endinterface : fpwi_timer_if
